/* hdl/flash_seq_pkg.sv */
// shared constants and types of the serial flash command sequencer
// assumes a 100 MHz system clock; times are kept in printed units
package flash_seq_pkg;
  // system clock period
  localparam int CLK_PERIOD_NS = 10;
  // printed times in their own units
  localparam int T_CSB_NS = 200;
  localparam int T_XFR_US = 250;
  localparam int T_EP_MS = 20;
  localparam int T_P_MS = 14;
  localparam int T_PE_MS = 8;
  localparam int T_BE_MS = 12;
  // longest times in whole cycles, rounded down
  localparam int CSB_CYC = T_CSB_NS / CLK_PERIOD_NS;
  localparam int XFR_CYC = T_XFR_US * 1000 / CLK_PERIOD_NS;
  localparam int EP_CYC = T_EP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int P_CYC = T_P_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PE_CYC = T_PE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BE_CYC = T_BE_MS * 1000000 / CLK_PERIOD_NS;
  // frame layout in bytes: opcode, address, dummy
  localparam logic [3:0] HDR_STATUS = 4'h1;
  localparam logic [3:0] HDR_ADDR = 4'h4;
  localparam logic [3:0] HDR_BUF = 4'h5;
  localparam logic [3:0] HDR_ARRAY = 4'h8;
  localparam logic [3:0] BYTE_CNT_MAX = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // address field positions, spare bit 23 ignored
  localparam int PAGE_ADDR_MSB = 22;
  localparam int PAGE_ADDR_LSB = 10;
  localparam int BYTE_ADDR_MSB = 9;
  // low bits of the status byte
  localparam logic [6:0] STATUS_LOW = 7'h00;
  // read opcodes, inactive-polarity set then spi set
  localparam logic [7:0] OP_CAR_A = 8'h68;
  localparam logic [7:0] OP_CAR_S = 8'he8;
  localparam logic [7:0] OP_PRD_A = 8'h52;
  localparam logic [7:0] OP_PRD_S = 8'hd2;
  localparam logic [7:0] OP_B1R_A = 8'h54;
  localparam logic [7:0] OP_B1R_S = 8'hd4;
  localparam logic [7:0] OP_B2R_A = 8'h56;
  localparam logic [7:0] OP_B2R_S = 8'hd6;
  localparam logic [7:0] OP_STA_A = 8'h57;
  localparam logic [7:0] OP_STA_S = 8'hd7;
  // opcodes starting internal work or carrying data
  localparam logic [7:0] OP_XFR1 = 8'h53;
  localparam logic [7:0] OP_XFR2 = 8'h55;
  localparam logic [7:0] OP_CMP1 = 8'h60;
  localparam logic [7:0] OP_CMP2 = 8'h61;
  localparam logic [7:0] OP_EP1 = 8'h83;
  localparam logic [7:0] OP_EP2 = 8'h86;
  localparam logic [7:0] OP_MP1 = 8'h82;
  localparam logic [7:0] OP_MP2 = 8'h85;
  localparam logic [7:0] OP_RW1 = 8'h58;
  localparam logic [7:0] OP_RW2 = 8'h59;
  localparam logic [7:0] OP_PG1 = 8'h88;
  localparam logic [7:0] OP_PG2 = 8'h89;
  localparam logic [7:0] OP_PER = 8'h81;
  localparam logic [7:0] OP_BER = 8'h50;
  localparam logic [7:0] OP_BW1 = 8'h84;
  localparam logic [7:0] OP_BW2 = 8'h87;
  // decoded command classes
  typedef enum logic [3:0] {
    CMD_NONE, CMD_CAR, CMD_PAGE_RD, CMD_BUF1_RD, CMD_BUF2_RD,
    CMD_STATUS, CMD_XFR, CMD_EP, CMD_PROG, CMD_PE, CMD_BE, CMD_WRITE
  } cmd_e;
  // address of a command
  typedef struct packed {
    logic [12:0] page;
    logic [9:0] col;
  } addr_s;
endpackage

/* hdl/serial_flash_command_timing.sv */
// serial command front end of a page-organised flash, device side
// assumes pins come from another domain; user logic shares i_sys_clk
//
// Contract
// - busy low within 200 ns of select rise
// - transfer or compare done within 250 us
// - program and erase done within stated times
// - either clock idle level; sample on rise
// - idle low mode 0, idle high mode 3
// - bytes of eight clocks, msb first
// - array read decoded from 68h or e8h
// - page read decoded from 52h or d2h
// - buffer reads from 54h/56h or d4h/d6h
// - status read decoded from 57h or d7h
// - address is spare, 13-bit page, 10-bit column
`timescale 1ns/100ps
module serial_flash_command_timing #(
  parameter int XFR_CYCLES = flash_seq_pkg::XFR_CYC,
  parameter int EP_CYCLES = flash_seq_pkg::EP_CYC,
  parameter int P_CYCLES = flash_seq_pkg::P_CYC,
  parameter int PE_CYCLES = flash_seq_pkg::PE_CYC,
  parameter int BE_CYCLES = flash_seq_pkg::BE_CYC,
  parameter int FIFO_DEPTH = 4
) (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // serial link pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  output logic o_rdy_busy,
  // decoded frame
  output flash_seq_pkg::cmd_e o_cmd,
  output flash_seq_pkg::addr_s o_addr,
  output logic o_clk_idle_high,
  // read data source
  input wire logic [7:0] i_rd_data,
  output logic o_rd_req,
  // write data stream
  output logic [7:0] o_wr_data,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic o_wr_overrun
);
  import flash_seq_pkg::*;

  // the busy counter is sized by the longest operation
  localparam int BUSY_W = $clog2(EP_CYCLES + 1);
  localparam int CSB_LIM = CSB_CYC;
  if (XFR_CYCLES < 1 || P_CYCLES < 1 || PE_CYCLES < 1 ||
      BE_CYCLES < 1 || XFR_CYCLES > EP_CYCLES ||
      P_CYCLES > EP_CYCLES || PE_CYCLES > EP_CYCLES ||
      BE_CYCLES > EP_CYCLES) begin : g_bad_cycles
    $error("operation cycle counts must be 1..EP_CYCLES");
  end

  // pin synchronisers: cs, sck, si
  logic [2:0] pin_meta_reg;  // first stage, read only by second
  logic [2:0] pin_sync_reg;  // second stage
  logic sck_prev_reg;  // sck one cycle back
  logic cs_prev_reg;  // cs one cycle back
  wire cs_s = pin_sync_reg[2];
  wire sck_s = pin_sync_reg[1];
  wire si_s = pin_sync_reg[0];
  wire cs_act = ~cs_s;  // select low
  wire cs_fall = cs_prev_reg & ~cs_s;
  wire cs_rise = ~cs_prev_reg & cs_s;
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sck_fall = ~sck_s & sck_prev_reg;

  // frame state
  logic [2:0] bit_cnt_reg;  // rising edges within the byte
  logic [3:0] byte_cnt_reg;  // whole bytes in frame, saturating
  logic [7:0] rx_sh_reg;  // incoming bits
  logic [15:0] addr_sh_reg;  // first two address bytes
  cmd_e cmd_reg;  // decoded opcode
  addr_s addr_reg;  // decoded address
  logic mode_reg;  // clock level at select fall
  logic [7:0] tx_sh_reg;  // outgoing bits
  logic tx_on_reg;  // output driven
  logic busy_reg;  // internal operation running
  logic [BUSY_W-1:0] busy_cnt_reg;  // cycles left
  logic overrun_reg;  // write byte lost

  // byte assembly, msb first
  wire [7:0] rx_byte = {rx_sh_reg[6:0], si_s};
  wire bit_step = sck_rise & cs_act;
  wire byte_done = bit_step & (bit_cnt_reg == BIT_LAST);
  wire [23:0] addr_full = {addr_sh_reg, rx_byte};

  // opcode decode, both opcode sets accepted
  function automatic cmd_e decode(input logic [7:0] op);
    case (op)
      OP_CAR_A, OP_CAR_S: decode = CMD_CAR;
      OP_PRD_A, OP_PRD_S: decode = CMD_PAGE_RD;
      OP_B1R_A, OP_B1R_S: decode = CMD_BUF1_RD;
      OP_B2R_A, OP_B2R_S: decode = CMD_BUF2_RD;
      OP_STA_A, OP_STA_S: decode = CMD_STATUS;
      OP_XFR1, OP_XFR2, OP_CMP1, OP_CMP2: decode = CMD_XFR;
      OP_EP1, OP_EP2, OP_MP1, OP_MP2, OP_RW1, OP_RW2: decode = CMD_EP;
      OP_PG1, OP_PG2: decode = CMD_PROG;
      OP_PER: decode = CMD_PE;
      OP_BER: decode = CMD_BE;
      OP_BW1, OP_BW2: decode = CMD_WRITE;
      default: decode = CMD_NONE;
    endcase
  endfunction

  // worst-case duration of the operation a command starts
  function automatic logic [BUSY_W-1:0] dur_of(input cmd_e c);
    case (c)
      CMD_XFR: dur_of = BUSY_W'(XFR_CYCLES);
      CMD_EP: dur_of = BUSY_W'(EP_CYCLES);
      CMD_PROG: dur_of = BUSY_W'(P_CYCLES);
      CMD_PE: dur_of = BUSY_W'(PE_CYCLES);
      CMD_BE: dur_of = BUSY_W'(BE_CYCLES);
      default: dur_of = '0;
    endcase
  endfunction

  // command classes
  wire is_status = cmd_reg == CMD_STATUS;
  wire is_array = cmd_reg == CMD_CAR || cmd_reg == CMD_PAGE_RD;
  wire is_buf = cmd_reg == CMD_BUF1_RD || cmd_reg == CMD_BUF2_RD;
  wire is_read = is_status | is_array | is_buf;
  // header length before read data, dummies included
  wire [3:0] hdr_len = is_status ? HDR_STATUS :
                       is_array ? HDR_ARRAY : HDR_BUF;
  wire [BUSY_W-1:0] op_dur = dur_of(cmd_reg);
  // start an operation at frame end once address is complete
  wire op_start = cs_rise & (byte_cnt_reg >= HDR_ADDR) &
                  (op_dur != '0) & ~busy_reg;
  // output byte load and shift on falling clock
  wire tx_phase = is_read & (byte_cnt_reg >= hdr_len);
  wire tx_load = sck_fall & cs_act & tx_phase & (bit_cnt_reg == '0);
  wire tx_shift = sck_fall & cs_act & tx_on_reg & (bit_cnt_reg != '0);
  wire [7:0] tx_byte = is_status ? {~busy_reg, STATUS_LOW} : i_rd_data;
  // write data goes to the stream after the address
  wire wr_push = byte_done & ~is_read & (byte_cnt_reg >= HDR_ADDR);
  wire fifo_in_ready;

  // two-flop capture of the pins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_meta_reg <= 3'h7;
      pin_sync_reg <= 3'h7;
      sck_prev_reg <= 1'b1;  // matches the synchroniser, no false edge
      cs_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= {i_cs_n, i_sck, i_si};
      pin_sync_reg <= pin_meta_reg;
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_s;
    end
  end

  // bit and byte counting, sampling on rising clock
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || cs_fall) begin
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      rx_sh_reg <= '0;
    end else if (bit_step) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_sh_reg <= rx_byte;
      if (byte_done && byte_cnt_reg != BYTE_CNT_MAX)
        byte_cnt_reg <= byte_cnt_reg + 4'h1;
    end
  end

  // clock idle level caught at select fall
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) mode_reg <= 1'b0;
    else if (cs_fall) mode_reg <= sck_s;
  end

  // opcode and address capture
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd_reg <= CMD_NONE;
      addr_sh_reg <= '0;
      addr_reg <= '0;
    end else if (cs_fall) begin
      cmd_reg <= CMD_NONE;
    end else if (byte_done && !is_status) begin
      if (byte_cnt_reg == '0)
        cmd_reg <= decode(rx_byte);
      else if (byte_cnt_reg < HDR_ADDR - 4'h1)
        addr_sh_reg <= addr_full[15:0];
      else if (byte_cnt_reg == HDR_ADDR - 4'h1) begin
        // spare top bit dropped
        addr_reg.page <= addr_full[PAGE_ADDR_MSB:PAGE_ADDR_LSB];
        addr_reg.col <= addr_full[BYTE_ADDR_MSB:0];
      end
    end
  end

  // serial output, changes on falling clock
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || cs_rise || cs_fall) begin
      tx_sh_reg <= '0;
      tx_on_reg <= 1'b0;
    end else if (tx_load) begin
      tx_sh_reg <= tx_byte;
      tx_on_reg <= 1'b1;
    end else if (tx_shift) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // busy timer of the internal operation
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (op_start) begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= op_dur - 1'b1;
    end else if (busy_reg) begin
      if (busy_cnt_reg == '0) busy_reg <= 1'b0;
      else busy_cnt_reg <= busy_cnt_reg - 1'b1;
    end
  end

  // lost write byte, held until the next frame
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) overrun_reg <= 1'b0;
    else if (wr_push && !fifo_in_ready) overrun_reg <= 1'b1;
    else if (cs_fall) overrun_reg <= 1'b0;
  end

  // write data buffer towards the user
  stream_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(wr_push),
    .i_in_data(rx_byte),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_wr_valid),
    .o_out_data(o_wr_data),
    .i_out_ready(i_wr_ready)
  );

  // outputs
  assign o_so = tx_sh_reg[7];
  assign o_so_oe = tx_on_reg & cs_act;
  assign o_rdy_busy = ~busy_reg;
  assign o_cmd = cmd_reg;
  assign o_addr = addr_reg;
  assign o_clk_idle_high = mode_reg;
  assign o_rd_req = tx_load & ~is_status;
  assign o_wr_overrun = overrun_reg;

  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  property p_busy_fast;
    op_start |-> ##[1:CSB_LIM] !o_rdy_busy;
  endproperty
  a_busy_fast: assert property (p_busy_fast)
    else $error("busy not shown after select rise");

  property p_xfr_len;
    $fell(o_rdy_busy) && cmd_reg == CMD_XFR |->
      busy_cnt_reg == XFR_CYCLES - 1;
  endproperty
  a_xfr_len: assert property (p_xfr_len)
    else $error("transfer duration wrong");

  property p_busy_cap;
    !o_rdy_busy |-> busy_cnt_reg < EP_CYCLES;
  endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("busy count beyond longest operation");

  property p_busy_hold;
    !o_rdy_busy && busy_cnt_reg != '0 |=> !o_rdy_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("ready before operation finished");

  property p_sample_rise;
    bit_step |=> rx_sh_reg[0] == $past(si_s);
  endproperty
  a_sample_rise: assert property (p_sample_rise)
    else $error("input not sampled on rising clock");

  property p_mode;
    cs_fall |=> mode_reg == $past(sck_s);
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock idle level not captured");

  property p_byte8;
    byte_done && byte_cnt_reg != BYTE_CNT_MAX |=>
      bit_cnt_reg == '0 && byte_cnt_reg == $past(byte_cnt_reg) + 4'h1;
  endproperty
  a_byte8: assert property (p_byte8)
    else $error("byte count not advanced after eight bits");

  property p_dec_car;
    byte_done && byte_cnt_reg == '0 &&
      (rx_byte == OP_CAR_A || rx_byte == OP_CAR_S) |=> cmd_reg == CMD_CAR;
  endproperty
  a_dec_car: assert property (p_dec_car)
    else $error("array read opcode not decoded");

  property p_dec_stat;
    byte_done && byte_cnt_reg == '0 &&
      (rx_byte == OP_STA_A || rx_byte == OP_STA_S) |=>
      cmd_reg == CMD_STATUS;
  endproperty
  a_dec_stat: assert property (p_dec_stat)
    else $error("status read opcode not decoded");

  property p_addr;
    byte_done && byte_cnt_reg == HDR_ADDR - 4'h1 && !is_status |=>
      o_addr.page == $past(addr_full[PAGE_ADDR_MSB:PAGE_ADDR_LSB]);
  endproperty
  a_addr: assert property (p_addr)
    else $error("page address field wrong");

  c_status_read: cover property (tx_load && is_status);
  c_op_start: cover property (op_start);
  c_mode_high: cover property (cs_fall && sck_s);
  c_overrun: cover property (wr_push && !fifo_in_ready);
endmodule

/* hdl/stream_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // depth must be a power of two of at least two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage words
  logic [AW:0] wr_ptr_reg;  // write pointer with wrap bit
  logic [AW:0] rd_ptr_reg;  // read pointer with wrap bit
  wire full = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
  wire empty = wr_ptr_reg == rd_ptr_reg;
  wire push = i_in_valid & ~full;
  wire pop = o_out_valid & i_out_ready;
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem_reg[rd_ptr_reg[AW-1:0]];
  // pointer update
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
  // word store
  always_ff @(posedge i_sys_clk) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
  end
endmodule

/* verif/flash_host_model.sv */
// behavioural host controller that drives the flash command pins
// assumes the bench calls its tasks; pins move only at i_sys_clk rises
`timescale 1ns/100ps
module flash_host_model #(
  parameter int POWER_UP_CYC = 50
) (
  // system clock of the bench
  input wire logic i_sys_clk,
  // serial link towards the device
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so
);
  // deselected and quiet from time zero, so reset releases under cs high
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end

  // wait a number of system clock rises
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // hold off all commands after supply and reset come up (scaled wait)
  task automatic power_up();
    wait_cyc(POWER_UP_CYC);
  endtask

  // set the idle clock level, keep cs high, then select with setup time
  task automatic begin_frame(input logic idle_hi);
    o_sck <= idle_hi;
    wait_cyc(26);
    o_cs_n <= 1'b0;
    wait_cyc(26);
  endtask

  // one byte, msb first; si moves on the fall, so is sampled mid-high
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck <= 1'b0;
      o_si <= tx[i];
      wait_cyc(4);
      o_sck <= 1'b1;
      wait_cyc(2);
      rx[i] = i_so;
      wait_cyc(2);
    end
  endtask

  // return clock to idle, hold, deselect; si no longer shows old data
  task automatic end_frame(input logic idle_hi);
    o_sck <= idle_hi;
    wait_cyc(26);
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    wait_cyc(1);
  endtask
endmodule

/* verif/testbench.sv */
// self-checking bench for the serial flash command front end
// assumes flash_seq_pkg and the design files are compiled first
`timescale 1ns/100ps
module testbench;
  import flash_seq_pkg::*;
  // shortened busy times and the run ceiling
  localparam int XFR_N = 400;
  localparam int EP_N = 600;
  localparam int P_N = 500;
  localparam int PE_N = 450;
  localparam int BE_N = 550;
  localparam int LIMIT = 30000;
  // read opcodes with their classes
  localparam logic [7:0] RD_OP [8] = '{8'h68, 8'he8, 8'h52, 8'hd2,
    8'h54, 8'hd4, 8'h56, 8'hd6};
  localparam cmd_e RD_CMD [8] = '{CMD_CAR, CMD_CAR, CMD_PAGE_RD,
    CMD_PAGE_RD, CMD_BUF1_RD, CMD_BUF1_RD, CMD_BUF2_RD, CMD_BUF2_RD};
  // operation opcodes, classes and busy lengths
  localparam logic [7:0] BZ_OP [6] = '{8'h53, 8'h60, 8'h83, 8'h88,
    8'h81, 8'h50};
  localparam cmd_e BZ_CMD [6] = '{CMD_XFR, CMD_XFR, CMD_EP, CMD_PROG,
    CMD_PE, CMD_BE};
  localparam int BZ_N [6] = '{XFR_N, XFR_N, EP_N, P_N, PE_N, BE_N};
  // clock, reset and user-side inputs
  logic i_sys_clk = 1'b0;
  logic i_rst;
  logic [7:0] i_rd_data;
  logic i_wr_ready;
  // pins and outputs
  logic cs_n, sck, si, so, so_oe, rdy_busy, idle_high, rd_req;
  cmd_e cmd;
  addr_s addr;
  logic [7:0] wr_data;
  logic wr_valid, wr_overrun;
  // bookkeeping
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int rd_pulses = 0;

  // 100 MHz system clock
  always #5 i_sys_clk = ~i_sys_clk;

  // device under test with short busy counts
  serial_flash_command_timing #(.XFR_CYCLES(XFR_N), .EP_CYCLES(EP_N),
    .P_CYCLES(P_N), .PE_CYCLES(PE_N), .BE_CYCLES(BE_N)
  ) uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
    .o_rdy_busy(rdy_busy), .o_cmd(cmd), .o_addr(addr),
    .o_clk_idle_high(idle_high), .i_rd_data(i_rd_data),
    .o_rd_req(rd_req), .o_wr_data(wr_data), .o_wr_valid(wr_valid),
    .i_wr_ready(i_wr_ready), .o_wr_overrun(wr_overrun));

  // host on the far side of the link
  flash_host_model host (.i_sys_clk(i_sys_clk),
    .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));

  // cycle count and read-request pulse count
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (rd_req === 1'b1) begin
      rd_pulses <= rd_pulses + 1;
    end
  end

  // cut a hang short
  always @(posedge i_sys_clk) begin
    if (cyc == LIMIT) begin
      fails++;
      tally_and_finish();
    end
  end

  // compare one value, count and report
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // counts, verdict, end of run
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // status read in a given mode; ready bit leads the byte
  task automatic t_status(input logic [7:0] op, input logic idle_hi,
    input logic [7:0] exp);
    logic [7:0] rx;
    host.begin_frame(idle_hi);
    host.xfer(op, rx);
    host.xfer(8'h00, rx);
    check("status byte", rx, exp);
    check("so enable", so_oe, 1'b1);
    check("idle level", idle_high, idle_hi);
    check("status command", cmd, CMD_STATUS);
    host.end_frame(idle_hi);
  endtask

  // read command: decode, address split, dummy bytes, first data byte
  task automatic t_read(input int k);
    logic [7:0] rx;
    logic [23:0] a;
    int pulses;
    a = {1'b0, 13'h1abc ^ 13'(k), 10'h2c5 - 10'(k)};
    i_rd_data <= RD_OP[k] ^ 8'h5a;
    host.begin_frame(k[0]);
    host.xfer(RD_OP[k], rx);
    for (int b = 2; b >= 0; b--) begin
      host.xfer(a[b*8 +: 8], rx);
    end
    repeat (k < 4 ? 4 : 1) host.xfer(8'hff, rx);
    pulses = rd_pulses;
    host.xfer(8'h00, rx);
    check("read byte", rx, RD_OP[k] ^ 8'h5a);
    check("read requests", rd_pulses - pulses, 1);
    check("read command", cmd, RD_CMD[k]);
    check("page", addr.page, a[22:10]);
    check("column", addr.col, a[9:0]);
    host.end_frame(k[0]);
  endtask

  // operation command: busy delay, status while busy, busy length
  task automatic t_busy(input int k);
    logic [7:0] rx;
    int t0;
    host.begin_frame(1'b0);
    host.xfer(BZ_OP[k], rx);
    repeat (3) host.xfer(8'h00, rx);
    host.end_frame(1'b0);
    check("busy command", cmd, BZ_CMD[k]);
    t0 = cyc;
    while (rdy_busy !== 1'b0 && cyc - t0 < 40) begin
      @(posedge i_sys_clk);
    end
    check("busy delay", (cyc - t0) <= 20, 1'b1);
    t0 = cyc;
    t_status(8'hd7, 1'b0, 8'h00);
    // the host waits for ready before any further operation
    while (rdy_busy !== 1'b1 && cyc - t0 < BZ_N[k] + 100) begin
      @(posedge i_sys_clk);
    end
    check("busy length", (cyc - t0 >= BZ_N[k] - 1)
      && (cyc - t0 <= BZ_N[k] + 1), 1'b1);
  endtask

  // three bytes only: no operation may start
  task automatic t_short();
    logic [7:0] rx;
    int lows;
    host.begin_frame(1'b1);
    host.xfer(8'h81, rx);
    repeat (2) host.xfer(8'h00, rx);
    host.end_frame(1'b1);
    lows = 0;
    repeat (30) begin
      @(posedge i_sys_clk);
      if (rdy_busy !== 1'b1) begin
        lows++;
      end
    end
    check("short frame busy", lows, 0);
  endtask

  // write stream: overfill the buffer while stalled, then drain
  task automatic t_write();
    logic [7:0] rx;
    int got;
    host.begin_frame(1'b1);
    host.xfer(8'h84, rx);
    repeat (3) host.xfer(8'h00, rx);
    for (int b = 0; b < 6; b++) begin
      host.xfer(8'hc0 + 8'(b), rx);
    end
    host.end_frame(1'b1);
    check("overrun", wr_overrun, 1'b1);
    check("write command", cmd, CMD_WRITE);
    i_wr_ready <= 1'b1;
    got = 0;
    for (int w = 0; w < 20 && got < 4; w++) begin
      @(posedge i_sys_clk);
      if (wr_valid === 1'b1) begin
        check("write data", wr_data, 8'hc0 + 8'(got));
        got++;
      end
    end
    i_wr_ready <= 1'b0;
    check("drained count", got, 4);
    @(posedge i_sys_clk);
    check("buffer empty", wr_valid, 1'b0);
    host.begin_frame(1'b0);
    check("overrun cleared", wr_overrun, 1'b0);
    host.end_frame(1'b0);
  endtask

  // main sequence
  initial begin
    i_rst <= 1'b1;
    i_rd_data <= 8'h00;
    i_wr_ready <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    host.power_up();
    check("reset ready", rdy_busy, 1'b1);
    check("reset so enable", so_oe, 1'b0);
    check("reset command", cmd, CMD_NONE);
    t_status(8'h57, 1'b0, 8'h80);
    t_status(8'h57, 1'b1, 8'h80);
    t_status(8'hd7, 1'b0, 8'h80);
    t_status(8'hd7, 1'b1, 8'h80);
    for (int k = 0; k < 8; k++) begin
      t_read(k);
    end
    for (int k = 0; k < 6; k++) begin
      t_busy(k);
    end
    t_short();
    t_write();
    tally_and_finish();
  end
endmodule
